// ==== hdl/prd_decoder.sv ====
// Address decoder and access checker for the cluster private region.
// Assumes cores present one access at a time and each target answers
// with a one-cycle done pulse carrying its read data.
//
// What this block does
// RULE1 - The snoop control range takes byte and word sizes and refuses halfword and doubleword.
// RULE2 - A forbidden halfword or doubleword access aborts the requesting core with a slave error.
// RULE3 - A word write whose strobes are not all set aborts with a slave error.
// RULE4 - Requests from the coherency slave port never reach any register of the region.
// RULE5 - Offsets 0x0000 to 0x00ff select the snoop control unit registers.
// RULE6 - Offsets 0x0100 to 0x01ff select the per-core interrupt interfaces.
// RULE7 - Offsets 0x0200 to 0x02ff select the global timer.
// RULE8 - Offsets 0x0600 to 0x06ff select the private timers and watchdogs.
// RULE9 - Offsets 0x1000 to 0x1fff select the interrupt distributor.
// RULE10 - Offsets 0x0300 to 0x03ff and 0x0700 to 0x07ff reach no target and abort.
// RULE11 - The region is two 4KB pages based at the 19-bit base input on address bits 31 to 13.
// RULE12 - Timers and watchdogs accept only word accesses.
// RULE13 - Data is little-endian and load or store multiple accesses abort with a slave error.
// RULE14 - Unassigned offsets behave as reserved offsets.
// RULE15 - An abort goes back to the issuing core and a rejected write changes no target.
module prd_decoder
  import prd_pkg::*;
#(
  parameter int CORE_W = 1
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic [BASE_W-1:0]   private_region_base_input,
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire logic                req_write,
  input  wire logic [ADDR_W-1:0]   req_addr,
  input  wire logic [2:0]          req_size,
  input  wire logic [3:0]          req_strb,
  input  wire logic [31:0]         req_wdata,
  input  wire logic                req_multiple,
  input  wire logic                req_from_coherency_port,
  input  wire logic [CORE_W-1:0]   req_core,
  output logic                     tgt_valid,
  output logic [SEL_W-1:0]         tgt_sel,
  output logic                     tgt_write,
  output logic [OFS_W-1:0]         tgt_offset,
  output logic [3:0]               tgt_strb,
  output logic [31:0]              tgt_wdata,
  output logic [CORE_W-1:0]        tgt_core,
  input  wire logic                tgt_done,
  input  wire logic [31:0]         tgt_rdata,
  output logic                     rsp_valid,
  output logic                     rsp_error,
  output logic [31:0]              rsp_rdata,
  output logic [CORE_W-1:0]        rsp_core
);

  // Maps an in-region offset to its target; gaps decode to none.
  function automatic prd_target_type decode_offset(input logic [OFS_W-1:0] ofs);
    prd_target_type t;
    t = TGT_NONE;
    // RULE5 snoop control window.
    if (ofs >= SCU_LO && ofs <= SCU_HI) begin
      t = TGT_SCU;
    end
    // RULE6 interrupt interface window.
    if (ofs >= ICI_LO && ofs <= ICI_HI) begin
      t = TGT_ICI;
    end
    // RULE7 global timer window.
    if (ofs >= GTM_LO && ofs <= GTM_HI) begin
      t = TGT_GTM;
    end
    // RULE8 private timer window.
    if (ofs >= PTM_LO && ofs <= PTM_HI) begin
      t = TGT_PTM;
    end
    // RULE9 distributor page.
    if (ofs >= DIST_LO && ofs <= DIST_HI) begin
      t = TGT_DIST;
    end
    // RULE10 reserved windows.
    if ((ofs >= RSV1_LO && ofs <= RSV1_HI) ||
        (ofs >= RSV2_LO && ofs <= RSV2_HI)) begin
      t = TGT_NONE;
    end
    return t;
  endfunction : decode_offset

  // Tells whether a size is legal for a target.
  function automatic logic size_allowed(input prd_target_type t,
                                        input logic [2:0] size);
    logic ok;
    ok = 1'b0;
    unique case (t)
      // RULE12 timers take words only.
      TGT_GTM, TGT_PTM: ok = (size == SIZE_WORD);
      // RULE1 byte or word, never halfword or doubleword.
      TGT_SCU, TGT_ICI, TGT_DIST: ok = (size == SIZE_BYTE) || (size == SIZE_WORD);
      TGT_NONE: ok = 1'b0;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : size_allowed

  // The base pins are a strap from outside logic, so they are synchronised.
  logic [BASE_W-1:0] base_meta;
  logic [BASE_W-1:0] base_sync;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      base_meta <= '0;
      base_sync <= '0;
    end else begin
      base_meta <= private_region_base_input;
      base_sync <= base_meta;
    end
  end

  // Held request and sequencer state.
  prd_state_type     state;
  logic              q_write;
  logic [OFS_W-1:0]  q_ofs;
  logic [3:0]        q_strb;
  logic [31:0]       q_wdata;
  logic [CORE_W-1:0] q_core;
  logic [SEL_W-1:0]  q_sel;
  logic              q_error;
  logic [31:0]       q_rdata;

  prd_state_type     next_state;
  logic              next_write;
  logic [OFS_W-1:0]  next_ofs;
  logic [3:0]        next_strb;
  logic [31:0]       next_wdata;
  logic [CORE_W-1:0] next_core;
  logic [SEL_W-1:0]  next_sel;
  logic              next_error;
  logic [31:0]       next_rdata;

  // Checks on the presented request.
  logic           accept;
  logic           in_region;
  logic [OFS_W-1:0] req_ofs;
  prd_target_type req_tgt;
  logic           bad_word;
  logic           fault;

  assign req_ready = (state == ST_IDLE);
  assign accept    = req_valid && req_ready;
  assign req_ofs   = req_addr[OFS_W-1:0];
  assign req_tgt   = decode_offset(req_ofs);

  // RULE11 two pages above the synchronised base.
  assign in_region = (req_addr[ADDR_W-1:BASE_LSB] == base_sync);

  // RULE3 word must carry all strobes; misaligned words are refused too.
  assign bad_word = (req_size == SIZE_WORD) &&
                    ((req_strb != STRB_FULL) || (req_addr[1:0] != WORD_ALIGN));

  // RULE14 unassigned gaps fall out as no target and hence fault.
  // RULE4 coherency port traffic and RULE13 multiples are refused here.
  // RULE2 forbidden halfword and doubleword sizes abort through the size check.
  assign fault = !in_region || req_from_coherency_port || req_multiple ||
                 (req_tgt == TGT_NONE) || !size_allowed(req_tgt, req_size) ||
                 bad_word;

  // Next values of the sequencer and the held request.
  always_comb begin
    next_state = state;
    next_write = q_write;
    next_ofs   = q_ofs;
    next_strb  = q_strb;
    next_wdata = q_wdata;
    next_core  = q_core;
    next_sel   = q_sel;
    next_error = q_error;
    next_rdata = q_rdata;
    unique case (state)
      ST_IDLE: begin
        if (accept) begin
          next_core  = req_core;
          next_write = req_write;
          next_ofs   = req_ofs;
          next_strb  = req_strb;
          next_wdata = req_wdata;
          next_rdata = DATA_RST;
          // RULE15 a fault skips the target so no register state moves.
          if (fault) begin
            next_error = 1'b1;
            next_sel   = SEL_NONE;
            next_state = ST_RESP;
          end else begin
            next_error = 1'b0;
            next_sel   = SEL_W'(1) << (3'(req_tgt) - 3'd1);
            next_state = ST_ISSUE;
          end
        end
      end
      ST_ISSUE: begin
        // Data passes unswapped: the region is little-endian only.
        if (tgt_done) begin
          next_rdata = q_write ? DATA_RST : tgt_rdata;
          next_sel   = SEL_NONE;
          next_state = ST_RESP;
        end
      end
      ST_RESP: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Registers of the sequencer.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state   <= ST_IDLE;
      q_write <= 1'b0;
      q_ofs   <= '0;
      q_strb  <= '0;
      q_wdata <= DATA_RST;
      q_core  <= '0;
      q_sel   <= SEL_NONE;
      q_error <= 1'b0;
      q_rdata <= DATA_RST;
    end else begin
      state   <= next_state;
      q_write <= next_write;
      q_ofs   <= next_ofs;
      q_strb  <= next_strb;
      q_wdata <= next_wdata;
      q_core  <= next_core;
      q_sel   <= next_sel;
      q_error <= next_error;
      q_rdata <= next_rdata;
    end
  end

  // Target side outputs come straight from the held request.
  assign tgt_valid  = (state == ST_ISSUE);
  assign tgt_sel    = q_sel;
  assign tgt_write  = q_write;
  assign tgt_offset = q_ofs;
  assign tgt_strb   = q_strb;
  assign tgt_wdata  = q_wdata;
  assign tgt_core   = q_core;

  // RULE15 the answer carries the issuing core back.
  assign rsp_valid = (state == ST_RESP);
  assign rsp_error = (state == ST_RESP) && q_error;
  assign rsp_rdata = q_rdata;
  assign rsp_core  = q_core;

  // Checks on the decoder's behaviour.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_coherency_refused: assert property ( // RULE4
    accept && req_from_coherency_port |=> rsp_valid && rsp_error && !tgt_valid)
    else $error("coherency port access was not refused");

  a_scu_size_check: assert property ( // RULE1
    accept && in_region && req_ofs <= SCU_HI && req_size == SIZE_DWORD
    |=> rsp_error)
    else $error("doubleword access to snoop control was not aborted");

  a_half_abort: assert property ( // RULE2
    accept && req_size == SIZE_HALF |=> rsp_valid && rsp_error)
    else $error("halfword access was not aborted");

  a_strobe_abort: assert property ( // RULE3
    accept && req_size == SIZE_WORD && req_strb != STRB_FULL
    |=> rsp_valid && rsp_error)
    else $error("partial strobe word was not aborted");

  a_scu_route: assert property ( // RULE5
    accept && !fault && req_ofs <= SCU_HI
    |=> tgt_valid && tgt_sel == 5'h01)
    else $error("snoop control offset not routed");

  a_dist_route: assert property ( // RULE9
    accept && !fault && req_ofs[12]
    |=> tgt_valid && tgt_sel == 5'h10)
    else $error("distributor offset not routed");

  a_ptm_route: assert property ( // RULE8
    accept && !fault && req_ofs >= PTM_LO && req_ofs <= PTM_HI
    |=> tgt_valid && tgt_sel == 5'h08)
    else $error("private timer offset not routed");

  a_gap_abort: assert property ( // RULE14
    accept && req_ofs >= 13'h0400 && req_ofs <= 13'h05ff
    |=> rsp_valid && rsp_error && !tgt_valid)
    else $error("unassigned offset was not aborted");

  a_reserved_abort: assert property ( // RULE10
    accept && req_ofs >= RSV1_LO && req_ofs <= RSV1_HI
    |=> rsp_valid && rsp_error ##1 !tgt_valid)
    else $error("reserved offset was not aborted");

  a_timer_byte: assert property ( // RULE12
    accept && req_ofs >= GTM_LO && req_ofs <= GTM_HI && req_size == SIZE_BYTE
    |=> rsp_error)
    else $error("byte access to timer was not aborted");

  a_multiple_abort: assert property ( // RULE13
    accept && req_multiple |=> rsp_valid && rsp_error)
    else $error("multiple access was not aborted");

  a_error_core: assert property ( // RULE15
    accept && fault |=> rsp_valid && rsp_core == $past(req_core) && !tgt_valid)
    else $error("abort went to wrong core or reached a target");

endmodule : prd_decoder

// ==== common/prd_pkg.sv ====
// Constants and types shared by the private region decoder.
// Assumes a 32-bit byte address and a region of two 4KB pages.
package prd_pkg;

  // Widths of the address, base and in-region offset.
  localparam int ADDR_W = 32;
  localparam int BASE_W = 19;
  localparam int OFS_W  = 13;
  localparam int BASE_LSB = 13;
  localparam int SEL_W  = 5;

  // Offset windows inside the region, inclusive bounds.
  localparam logic [12:0] SCU_LO  = 13'h0000;
  localparam logic [12:0] SCU_HI  = 13'h00ff;
  localparam logic [12:0] ICI_LO  = 13'h0100;
  localparam logic [12:0] ICI_HI  = 13'h01ff;
  localparam logic [12:0] GTM_LO  = 13'h0200;
  localparam logic [12:0] GTM_HI  = 13'h02ff;
  localparam logic [12:0] RSV1_LO = 13'h0300;
  localparam logic [12:0] RSV1_HI = 13'h03ff;
  localparam logic [12:0] PTM_LO  = 13'h0600;
  localparam logic [12:0] PTM_HI  = 13'h06ff;
  localparam logic [12:0] RSV2_LO = 13'h0700;
  localparam logic [12:0] RSV2_HI = 13'h07ff;
  localparam logic [12:0] DIST_LO = 13'h1000;
  localparam logic [12:0] DIST_HI = 13'h1fff;

  // Transfer size codes on the core side.
  localparam logic [2:0] SIZE_BYTE  = 3'h0;
  localparam logic [2:0] SIZE_HALF  = 3'h1;
  localparam logic [2:0] SIZE_WORD  = 3'h2;
  localparam logic [2:0] SIZE_DWORD = 3'h3;
  localparam logic [3:0] STRB_FULL  = 4'hf;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // Reset values of the held request.
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [4:0]  SEL_NONE = 5'h00;

  // Decoded destination of an access.
  typedef enum logic [2:0] {
    TGT_NONE = 3'b000,
    TGT_SCU  = 3'b001,
    TGT_ICI  = 3'b010,
    TGT_GTM  = 3'b011,
    TGT_PTM  = 3'b100,
    TGT_DIST = 3'b101
  } prd_target_type;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_RESP  = 2'b10
  } prd_state_type;

endpackage : prd_pkg

// ==== sim/prd_target_model.sv ====
// Behavioural model of the register targets behind the private region decoder.
// Assumes one access at a time and a latency chosen by the bench on lat.
module prd_target_model
  import prd_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             tgt_valid,
  input  wire logic [SEL_W-1:0] tgt_sel,
  input  wire logic [OFS_W-1:0] tgt_offset,
  input  wire logic [3:0]       lat,
  output logic                  tgt_done,
  output logic [31:0]           tgt_rdata
);
  logic [3:0] cnt;

  // little-endian data
  // Read data is sent unswapped and names the target and offset, so the
  // bench can predict it; between answers the data bus toggles so that a
  // stale value never passes for a fresh one.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt       <= 4'h0;
      tgt_done  <= 1'b0;
      tgt_rdata <= 32'hffff_ffff;
    end else if (tgt_valid && !tgt_done && cnt == lat) begin
      cnt       <= 4'h0;
      tgt_done  <= 1'b1;
      tgt_rdata <= {tgt_sel, tgt_offset, 14'h0000};
    end else begin
      tgt_done  <= 1'b0;
      tgt_rdata <= ~tgt_rdata;
      if (tgt_valid && !tgt_done) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : prd_target_model

// ==== sim/tb_prd_decoder.sv ====
// Self-checking bench for the private region decoder.
// Assumes the target model in prd_target_model and a fixed region base.
module tb_prd_decoder;
  import prd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [18:0] BASE = 19'h5a5a5;
  logic clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  logic req_multiple = 1'b0, req_from_coherency_port = 1'b0, req_ready;
  logic [ADDR_W-1:0] req_addr = 32'h0;
  logic [2:0] req_size = 3'h0;
  logic [3:0] req_strb = 4'h0, lat = 4'h0, tgt_strb;
  logic [31:0] req_wdata = 32'h0, tgt_wdata, tgt_rdata, rsp_rdata;
  logic [0:0] req_core = 1'b0, tgt_core, rsp_core;
  logic tgt_valid, tgt_write, tgt_done, rsp_valid, rsp_error, tv_d = 1'b0;
  logic [SEL_W-1:0] tgt_sel, last_sel = 5'h00;
  logic last_write = 1'b0, last_core = 1'b0;
  logic [3:0] last_strb = 4'h0;
  logic [31:0] last_wdata = 32'h0;
  logic [OFS_W-1:0] last_ofs = 13'h0000;
  logic [OFS_W-1:0] tgt_offset;
  int failures = 0, tests_run = 0, rises = 0;

  prd_decoder #(.CORE_W(1)) u_prd_decoder (.clk(clk), .sys_rst(sys_rst),
    .private_region_base_input(BASE), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_size(req_size), .req_strb(req_strb), .req_wdata(req_wdata),
    .req_multiple(req_multiple), .req_from_coherency_port(req_from_coherency_port),
    .req_core(req_core), .tgt_valid(tgt_valid), .tgt_sel(tgt_sel),
    .tgt_write(tgt_write), .tgt_offset(tgt_offset), .tgt_strb(tgt_strb),
    .tgt_wdata(tgt_wdata), .tgt_core(tgt_core), .tgt_done(tgt_done),
    .tgt_rdata(tgt_rdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .rsp_rdata(rsp_rdata), .rsp_core(rsp_core));
  prd_target_model u_prd_target_model (.clk(clk), .sys_rst(sys_rst),
    .tgt_valid(tgt_valid), .tgt_sel(tgt_sel), .tgt_offset(tgt_offset),
    .lat(lat), .tgt_done(tgt_done), .tgt_rdata(tgt_rdata));

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  // Counts target accesses, so an abort that leaks to a target is seen.
  always @(posedge clk) begin
    if (tgt_valid === 1'b1 && tv_d !== 1'b1) begin
      rises++;
      last_sel = tgt_sel;
      last_write = tgt_write;
      last_core = tgt_core[0];
      last_strb = tgt_strb;
      last_wdata = tgt_wdata;
      last_ofs = tgt_offset;
    end
    tv_d <= tgt_valid;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // One core access; es is the expected one-hot target, zero for an abort.
  task automatic acc(input logic w, input logic [31:0] a, input logic [2:0] sz,
                     input logic [3:0] st, input logic m, input logic c,
                     input logic cr, input logic [4:0] es);
    int n;
    int r0;
    logic ee;
    ee = (es == 5'h00);
    r0 = rises;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_size <= sz;
    req_strb <= st;
    req_multiple <= m;
    req_from_coherency_port <= c;
    req_core <= cr;
    req_wdata <= ~a;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 40);
    chk("latency", ee ? 1 : 3 + lat, n);
    chk("rsp_error", {31'h0, ee}, {31'h0, rsp_error});
    chk("rsp_core", {31'h0, cr}, {31'h0, rsp_core});
    chk("rsp_rdata", (ee || w) ? 32'h0 : {es, a[12:0], 14'h0000}, rsp_rdata);
    chk("tgt_access", ee ? r0 : r0 + 1, rises);
    if (!ee) chk("tgt_sel", {27'h0, es}, {27'h0, last_sel});
    if (!ee) chk("tgt_write", {31'h0, w}, {31'h0, last_write});
    if (!ee) chk("tgt_strb", {28'h0, st}, {28'h0, last_strb});
    if (!ee) chk("tgt_wdata", ~a, last_wdata);
    if (!ee) chk("tgt_core", {31'h0, cr}, {31'h0, last_core});
    if (!ee) chk("tgt_offset", {19'h0, a[12:0]}, {19'h0, last_ofs});
  endtask : acc

  task automatic t_scu;
    acc(0, {BASE, 13'h0000}, SIZE_WORD, 4'hf, 0, 0, 0, 5'h01);
    acc(1, {BASE, 13'h00fc}, SIZE_BYTE, 4'h8, 0, 0, 1, 5'h01);
    acc(0, {BASE, 13'h0004}, SIZE_HALF, 4'h3, 0, 0, 1, 5'h00);
    acc(0, {BASE, 13'h0008}, SIZE_DWORD, 4'hf, 0, 0, 0, 5'h00);
    acc(1, {BASE, 13'h0010}, SIZE_WORD, 4'h7, 0, 0, 1, 5'h00);
    acc(0, {BASE, 13'h0012}, SIZE_WORD, 4'hf, 0, 0, 0, 5'h00);
    $display("test scu done");
  endtask : t_scu

  task automatic t_periph;
    acc(0, {BASE, 13'h0100}, SIZE_WORD, 4'hf, 0, 0, 0, 5'h02);
    acc(0, {BASE, 13'h01ff}, SIZE_BYTE, 4'h8, 0, 0, 1, 5'h02);
    lat <= 4'h5;
    acc(0, {BASE, 13'h0200}, SIZE_WORD, 4'hf, 0, 0, 0, 5'h04);
    lat <= 4'h0;
    acc(0, {BASE, 13'h0204}, SIZE_BYTE, 4'h1, 0, 0, 0, 5'h00);
    acc(1, {BASE, 13'h06fc}, SIZE_WORD, 4'hf, 0, 0, 1, 5'h08);
    acc(0, {BASE, 13'h0600}, SIZE_HALF, 4'h3, 0, 0, 0, 5'h00);
    acc(0, {BASE, 13'h1000}, SIZE_WORD, 4'hf, 0, 0, 0, 5'h10);
    acc(0, {BASE, 13'h1fff}, SIZE_BYTE, 4'h8, 0, 0, 1, 5'h10);
    acc(0, {BASE, 13'h0104}, SIZE_HALF, 4'h3, 0, 0, 0, 5'h00);
    acc(1, {BASE, 13'h1008}, SIZE_DWORD, 4'hf, 0, 0, 1, 5'h00);
    acc(1, {BASE, 13'h0604}, SIZE_BYTE, 4'h1, 0, 0, 0, 5'h00);
    acc(0, {BASE, 13'h0208}, SIZE_DWORD, 4'hf, 0, 0, 1, 5'h00);
    acc(0, {BASE, 13'h0000}, 3'h4, 4'hf, 0, 0, 0, 5'h00);
    $display("test targets done");
  endtask : t_periph

  task automatic t_refuse;
    logic [12:0] ofs [6] = '{13'h0300, 13'h03ff, 13'h0400, 13'h05ff,
                              13'h0700, 13'h0ffc};
    foreach (ofs[i]) acc(1, {BASE, ofs[i]}, SIZE_BYTE, 4'h1, 0, 0, 1, 5'h00);
    acc(0, {BASE, 13'h0000}, SIZE_WORD, 4'hf, 0, 1, 0, 5'h00);
    acc(0, {BASE, 13'h1000}, SIZE_WORD, 4'hf, 1, 0, 1, 5'h00);
    acc(0, {BASE ^ 19'h00001, 13'h0000}, SIZE_WORD, 4'hf, 0, 0, 0, 5'h00);
    $display("test refusals done");
  endtask : t_refuse

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // Reset for three cycles, then two more so the base synchroniser settles.
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_scu();
    t_periph();
    t_refuse();
    end_of_test();
  end

  // The tests need well under a thousand cycles; this cuts a hang short.
  initial begin
    #50000;
    failures++;
    end_of_test();
  end
endmodule : tb_prd_decoder
